// file: dah_cfg.svh
// Constants for the dual converter hold queue and read port.
`ifndef DAH_CFG_SVH
`define DAH_CFG_SVH

// Result and channel geometry.
`define DAH_RESULT_W     12
`define DAH_NUM_CH       6
`define DAH_NUM_PAIRS    3

// Read mode patterns on the mode-select pins, and the last channel of cycle mode.
`define DAH_MODE_RESET   3'h0
`define DAH_MODE_CYCLE   3'h6
`define DAH_MODE_FIFO    3'h7
`define DAH_CYC_LAST     3'h5

// Conversion timing in conversion-clock cycles; the latch point in half cycles.
`define DAH_BUSY_CYC     13
`define DAH_LATCH_HALVES 25
`define DAH_MIN_CONV_CYC 16

// Same timing counted in conversion-clock edges (two per cycle).
`define DAH_LATCH_EDGE   6'(`DAH_LATCH_HALVES)
`define DAH_RESTART_EDGE 6'(2 * `DAH_MIN_CONV_CYC - 1)

`endif

// file: dah_pkg.sv
// Types shared by the converter control and its output store.
package dah_pkg;

  // Converter sequencer states.
  typedef enum logic [1:0] {
    DAH_ST_IDLE = 2'b00,
    DAH_ST_CONV = 2'b01,
    DAH_ST_ACQ  = 2'b10
  } dah_cstate_t;

  // Complete state of the control block.
  typedef struct packed {
    logic              cclk_d1;
    logic [2:0]        hold_d1;
    logic [2:0]        fell;
    logic [2:0]        held;
    logic [1:0]        qcnt;
    logic [2:0][1:0]   qid;
    dah_cstate_t       st;
    logic [5:0]        edges;
    logic [1:0]        cur;
    logic              busy;
    logic [2:0]        track;
    logic              rd_act;
    logic [2:0]        mode;
    logic [2:0]        cyc_ptr;
    logic [15:0]       word;
    logic              oe;
    logic              wr_pend;
    logic [23:0]       wr_data;
  } dah_ctl_t;

  // Six output registers, used by channel or as a queue.
  typedef struct packed {
    logic [5:0][15:0]  r;
    logic [2:0]        cnt;
  } dah_store_t;

endpackage : dah_pkg

// file: dah_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps

module dah_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dah_sync_t;

  dah_sync_t q;
  dah_sync_t d;

  // The first stage feeds only the second stage.
  always_comb begin
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  // Both stages reset to the idle level of the pin.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= {RST, RST};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;

endmodule : dah_sync

// file: dah_store.sv
// Six output registers with direct and queue access.
`timescale 1ns/10ps
`include "dah_cfg.svh"

module dah_store (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Write of one finished pair.
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_pair,
  input  wire logic [31:0] wr_words,
  input  wire logic        fifo_mode,
  // Read side.
  input  wire logic [2:0]  rd_sel,
  input  wire logic        pop,
  output logic      [15:0] rd_word
);

  dah_pkg::dah_store_t q;
  dah_pkg::dah_store_t d;

  // Pop shifts toward register 0, then in queue mode a write lands on the next free
  // pair of registers, or is dropped with no room; otherwise on its own pair.
  always_comb begin
    d = q;
    if (pop && (q.cnt != 3'h0)) begin
      for (int i = 0; i < `DAH_NUM_CH - 1; i++) begin
        d.r[i] = q.r[i+1];
      end
      d.r[`DAH_NUM_CH-1] = 16'h0000;
      d.cnt = q.cnt - 3'h1;
    end
    if (wr_en) begin
      if (fifo_mode) begin
        if (d.cnt <= 3'h4) begin
          d.r[d.cnt]        = wr_words[15:0];
          d.r[d.cnt + 3'h1] = wr_words[31:16];
          d.cnt             = d.cnt + 3'h2;
        end
      end else begin
        d.r[{wr_pair, 1'b0}] = wr_words[15:0];
        d.r[{wr_pair, 1'b1}] = wr_words[31:16];
      end
    end
  end

  // Reset empties every register, so the valid flag reads zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Queue mode always shows the oldest entry.
  assign rd_word = fifo_mode ? q.r[0] : q.r[rd_sel];

endmodule : dah_store

// file: dah_top.sv
// Hold queue, conversion sequencer and read port of a dual converter.
`timescale 1ns/10ps
`include "dah_cfg.svh"

module dah_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Conversion clock pin.
  input  wire logic        conv_clk,
  // Hold strobes, active low.
  input  wire logic        hold_req_pair_a_n,
  input  wire logic        hold_req_pair_b_n,
  input  wire logic        hold_req_pair_c_n,
  // Read strobes, active low, and mode-select pins.
  input  wire logic        rd_n,
  input  wire logic        cs_n,
  input  wire logic        mode_sel_bit0,
  input  wire logic        mode_sel_bit1,
  input  wire logic        mode_sel_bit2,
  // Results from the two converter cores.
  input  wire logic [11:0] adc_res_a,
  input  wire logic [11:0] adc_res_b,
  // Converter status and analog control.
  output logic             busy_q,
  output logic [2:0]       track_q,
  output logic [1:0]       mux_pair_q,
  // Output word, bit 15 is word_valid_flag.
  output logic [15:0]      word_q,
  output logic             word_oe_q
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic       cclk_s;
  logic [2:0] hold_s;
  logic [1:0] rdcs_s;
  logic [2:0] mode_s;

  // Clock, strobe and mode pins pass two flops before use; the converter results do not.
  dah_sync #(.W(1), .RST(1'b0)) u_sync_cclk (
    .clk     (clk),
    .arst_n  (arst_n),
    .async_i (conv_clk),
    .sync_o  (cclk_s)
  );

  dah_sync #(.W(3), .RST(3'h7)) u_sync_hold (
    .clk     (clk),
    .arst_n  (arst_n),
    .async_i ({hold_req_pair_c_n, hold_req_pair_b_n, hold_req_pair_a_n}),
    .sync_o  (hold_s)
  );

  dah_sync #(.W(2), .RST(2'h3)) u_sync_rdcs (
    .clk     (clk),
    .arst_n  (arst_n),
    .async_i ({cs_n, rd_n}),
    .sync_o  (rdcs_s)
  );

  dah_sync #(.W(3), .RST(3'h0)) u_sync_mode (
    .clk     (clk),
    .arst_n  (arst_n),
    .async_i ({mode_sel_bit2, mode_sel_bit1, mode_sel_bit0}),
    .sync_o  (mode_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // A mode pattern of 110 or 111 is not a direct channel address.
  function automatic logic dah_is_direct(input logic [2:0] m);
    dah_is_direct = (m != `DAH_MODE_CYCLE) && (m != `DAH_MODE_FIFO);
  endfunction : dah_is_direct

  // Result word: valid flag, channel code, result.
  function automatic logic [15:0] dah_pack(input logic [1:0] pair,
                                           input logic       second,
                                           input logic [11:0] res);
    dah_pack = {1'b1, pair, second, res};
  endfunction : dah_pack

  ////////////////////////////////////////////////////////////////////////
  // State and combinational helpers

  dah_pkg::dah_ctl_t q;
  dah_pkg::dah_ctl_t n;

  logic        cclk_rise;
  logic        cclk_fall;
  logic        rd_act;
  logic        rd_start;
  logic        rd_end;
  logic [2:0]  rd_mode;
  logic [2:0]  rd_sel;
  logic        wr_en;
  logic        pop;
  logic [15:0] rd_word;

  // Conversion-clock edges seen in the system clock domain.
  assign cclk_rise = cclk_s & ~q.cclk_d1;
  assign cclk_fall = ~cclk_s & q.cclk_d1;

  // A read is active only with both strobes low.
  assign rd_act   = ~rdcs_s[0] & ~rdcs_s[1];
  assign rd_start = rd_act & ~q.rd_act;
  assign rd_end   = ~rd_act & q.rd_act;

  // Mode pins only matter during a read, taken at its start.
  assign rd_mode = rd_start ? mode_s : q.mode;
  assign rd_sel  = dah_is_direct(rd_mode) ? rd_mode : q.cyc_ptr;

  // A pending result is written only while no read is active.
  assign wr_en = q.wr_pend & ~rd_act;
  assign pop   = rd_end & (q.mode == `DAH_MODE_FIFO);

  dah_store u_store (
    .clk       (clk),
    .arst_n    (arst_n),
    .wr_en     (wr_en),
    .wr_pair   (q.cur),
    .wr_words  ({dah_pack(q.cur, 1'b1, q.wr_data[23:12]),
                 dah_pack(q.cur, 1'b0, q.wr_data[11:0])}),
    .fifo_mode (rd_mode == `DAH_MODE_FIFO),
    .rd_sel    (rd_sel),
    .pop       (pop),
    .rd_word   (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // How a hold request travels through this block, cycle by cycle.
  // A strobe pin passes two synchroniser flops and is then compared with
  // the copy held one cycle back, so a falling pin shows up as a one-cycle
  // edge about three system clocks after it happens.
  // Edges are collected in the fell vector until the next falling edge of
  // the synchronised conversion clock. There they are moved into the hold
  // queue together, lowest pair first, which gives the A, B, C order for
  // strobes that fell within the same conversion-clock cycle.
  // A pair that is already waiting or converting has its held bit set,
  // and that bit masks any further edge on its strobe. The bit is cleared
  // only when the pair's result is stored, or by reset.
  // The sequencer starts the oldest queued pair on a rising edge of the
  // conversion clock. Busy falls on that same system clock edge and the
  // edge counter restarts from zero.
  // The counter advances on each conversion-clock edge once a pair has
  // started, rising and falling alike. On the twenty-fifth edge, which is a falling one, both
  // converter results are captured into the pending write buffer.
  // The pending write goes into the output registers on the next system
  // clock on which no read is active. Busy rises on that clock, which
  // means the stored word is already readable when the host sees busy
  // high, and the pair goes back to sampling.
  // The next start also waits for the counter to reach the end of a
  // sixteen-cycle frame. The counter saturates there, so a pair that is
  // held long after the previous conversion starts on the next rise.
  // Limitation: everything is sampled with the fast system clock, so the
  // conversion clock must stay several system clocks high and low for
  // its edges to be seen. The minimum high and low times of the clock pin
  // keep this true at the rates this block is built for.
  // Trade-off: a result that falls due during a long read is delayed, and
  // so is the next start, rather than changing the word under the host.
  // The host therefore sees busy stay low a little longer than usual.

  always_comb begin
    logic [2:0] take;
    take = 3'h0;
    n = q;
    n.cclk_d1 = cclk_s;
    n.hold_d1 = hold_s;

    // Only a high-to-low change counts, and a pair already held ignores
    // new pulses. Edges are gathered until the next falling clock edge.
    n.fell = q.fell | (q.hold_d1 & ~hold_s & ~q.held);

    // Requests are taken at the falling clock edge; simultaneous ones
    // enter the queue in the order A, B, C behind anything waiting.
    if (cclk_fall) begin
      take = n.fell;
      n.fell = 3'h0;
      for (int i = 0; i < `DAH_NUM_PAIRS; i++) begin
        if (take[i] && (n.qcnt < 2'h3)) begin
          n.qid[n.qcnt] = 2'(i);
          n.qcnt = n.qcnt + 2'h1;
        end
      end
      n.held  = q.held | take;
      n.track = q.track & ~take;
    end

    // Count conversion-clock edges while converting or acquiring.
    if ((cclk_rise || cclk_fall) && (q.st != dah_pkg::DAH_ST_IDLE) &&
        (q.edges != `DAH_RESTART_EDGE)) begin
      n.edges = q.edges + 6'h01;
    end

    unique case (q.st)
      dah_pkg::DAH_ST_IDLE,
      dah_pkg::DAH_ST_ACQ: begin
        // A queued pair starts on a rising edge once 16 cycles have passed
        // since the previous start and its result has been stored.
        if (cclk_rise && (q.qcnt != 2'h0) && !q.wr_pend &&
            ((q.st == dah_pkg::DAH_ST_IDLE) ||
             (q.edges == `DAH_RESTART_EDGE))) begin
          n.cur   = q.qid[0];
          n.qid   = {2'h0, q.qid[2], q.qid[1]};
          n.qcnt  = n.qcnt - 2'h1;
          n.busy  = 1'b0;
          n.edges = 6'h00;
          n.st    = dah_pkg::DAH_ST_CONV;
        end
      end
      dah_pkg::DAH_ST_CONV: begin
        // Both converter results are captured half a cycle before the
        // thirteenth rising edge; busy stays low until they are stored.
        if (cclk_fall && (n.edges == `DAH_LATCH_EDGE)) begin
          n.wr_pend = 1'b1;
          n.wr_data = {adc_res_b, adc_res_a};
          n.st      = dah_pkg::DAH_ST_ACQ;
        end
      end
      default: begin
        n.st = dah_pkg::DAH_ST_IDLE;
      end
    endcase

    // Storing the result ends the conversion: busy rises, the pair goes
    // back to sampling and its strobe is heard again.
    if (wr_en) begin
      n.wr_pend      = 1'b0;
      n.busy         = 1'b1;
      n.track[q.cur] = 1'b1;
      n.held[q.cur]  = 1'b0;
    end

    // Read port: the word is refreshed every cycle of the read; no result
    // is stored while a read is active, so it cannot change under the host.
    n.rd_act = rd_act;
    n.mode   = rd_mode;
    n.oe     = rd_act;
    n.word   = rd_act ? rd_word : 16'h0000;
    if (rd_end && (q.mode == `DAH_MODE_CYCLE)) begin
      n.cyc_ptr = (q.cyc_ptr == `DAH_CYC_LAST) ? 3'h0 : q.cyc_ptr + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Reset aborts everything, empties the queue and closes all switches;
  // the mode returns to 000 and cycle mode restarts at A0.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.hold_d1 <= 3'h7;
      q.busy    <= 1'b1;
      q.track   <= 3'h7;
      q.mode    <= `DAH_MODE_RESET;
      q.cyc_ptr <= 3'h0;
      q.st      <= dah_pkg::DAH_ST_IDLE;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a flop of the state record.
  assign busy_q     = q.busy;
  assign track_q    = q.track;
  assign mux_pair_q = q.cur;
  assign word_q     = q.word;
  assign word_oe_q  = q.oe;

endmodule : dah_top

// file: dah_host_model.sv
// Host-side conversion clock source for the converter control bench.
`timescale 1ns/10ps

module dah_host_model (
  // Clock and reset.
  input  logic clk,
  input  logic arst_n,
  // Conversion clock to the device.
  output logic conv_clk
);
  logic [3:0] div_q;

  // Toggle every 16 clocks; 128 ns keeps under the ceiling, runs short.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q    <= 4'h0;
      conv_clk <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'hF) conv_clk <= ~conv_clk;
    end
  end
endmodule : dah_host_model

// file: dah_top_properties.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps

module dah_top_properties (
  // Clock and reset.
  input logic        clk,
  input logic        arst_n,
  // Read strobes.
  input logic        rd_n,
  input logic        cs_n,
  // Outputs under watch.
  input logic        busy_q,
  input logic [2:0]  track_q,
  input logic [1:0]  mux_pair_q,
  input logic [15:0] word_q,
  input logic        word_oe_q
);
  logic [9:0] gap_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Cycles since the last start; saturates so reset never fakes a gap.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) gap_q <= 10'h3FF;
    else if ($fell(busy_q)) gap_q <= 10'h000;
    else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
  end

  ////////////////////////////////
  reset_values_a: assert property (
    $rose(arst_n) |-> busy_q && track_q == 3'h7 && !word_oe_q)
    else $error("Outputs not at reset values after reset.");
  busy_length_a: assert property (
    $fell(busy_q) |-> ##[399:700] $rose(busy_q))
    else $error("Busy low time does not match the conversion.");
  start_gap_a: assert property (
    $fell(busy_q) |-> gap_q >= 10'h1FF)
    else $error("Conversions started closer than 16 cycles.");
  done_track_a: assert property (
    $rose(busy_q) |-> track_q[mux_pair_q])
    else $error("Finished pair did not return to sampling.");
  conv_hold_a: assert property (
    !busy_q |-> !track_q[mux_pair_q])
    else $error("Pair sampling while it converts.");
  oe_gate_a: assert property (
    (rd_n || cs_n) [*4] |-> !word_oe_q)
    else $error("Output enabled without select and read.");
  oe_word_a: assert property (
    !word_oe_q |-> word_q == 16'h0000)
    else $error("Output word driven while disabled.");
  chan_code_a: assert property (
    word_oe_q && word_q[15] |-> word_q[14:12] <= 3'h5)
    else $error("Valid word carries an unknown channel.");
endmodule : dah_top_properties

bind dah_top dah_top_properties chk (.clk(clk), .arst_n(arst_n),
  .rd_n(rd_n), .cs_n(cs_n), .busy_q(busy_q), .track_q(track_q),
  .mux_pair_q(mux_pair_q), .word_q(word_q), .word_oe_q(word_oe_q));

// file: tb_dah_top.sv
// Self-checking bench for the converter hold queue and read port.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

module tb_dah_top;
  logic        clk, arst_n, conv_clk, rd_n, cs_n, busy_q, word_oe_q;
  logic [2:0]  hold_n, mode, track_q;
  logic [1:0]  mux_pair_q, p;
  logic [11:0] res_a, res_b;
  logic [15:0] word_q, w;
  int          fails, comparisons, cycles;

  dah_host_model host (.clk(clk), .arst_n(arst_n), .conv_clk(conv_clk));
  dah_top dut (.clk(clk), .arst_n(arst_n), .conv_clk(conv_clk),
    .hold_req_pair_a_n(hold_n[0]), .hold_req_pair_b_n(hold_n[1]),
    .hold_req_pair_c_n(hold_n[2]), .rd_n(rd_n), .cs_n(cs_n),
    .mode_sel_bit0(mode[0]), .mode_sel_bit1(mode[1]),
    .mode_sel_bit2(mode[2]), .adc_res_a(res_a), .adc_res_b(res_b),
    .busy_q(busy_q), .track_q(track_q), .mux_pair_q(mux_pair_q),
    .word_q(word_q), .word_oe_q(word_oe_q));

  // Free-running 250 MHz clock.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask : step

  // Reset held 24 ns, longer than two cycles so the host minimum holds.
  task automatic rst();
    arst_n <= 1'b0;
    step(6);
    arst_n <= 1'b1;
    step(6);
  endtask : rst

  // Strobes low for 32 ns, then released.
  task automatic hold(logic [2:0] m);
    hold_n <= ~m;
    step(8);
    hold_n <= 3'h7;
  endtask : hold

  // Wait one whole conversion and note the pair it served.
  task automatic conv();
    while (busy_q !== 1'b0) step(1);
    p = mux_pair_q;
    while (busy_q !== 1'b1) step(1);
  endtask : conv

  // One read with the mode pins set up well before the strobes fall.
  task automatic rd(logic [2:0] m);
    mode <= m;
    step(3);
    rd_n <= 1'b0;
    cs_n <= 1'b0;
    while (word_oe_q !== 1'b1) step(1);
    step(10);
    w = word_q;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    while (word_oe_q !== 1'b0) step(1);
    step(5);
  endtask : rd

  ////////////////////////////////
  task automatic t_reset();
    `CHK(busy_q, 1'b1)
    `CHK(track_q, 3'h7)
    rd(3'h0);
    `CHK(w, 16'h0000)
  endtask : t_reset

  task automatic t_gate();
    rd_n <= 1'b0;
    step(10);
    `CHK(word_oe_q, 1'b0)
    `CHK(word_q, 16'h0000)
    rd_n <= 1'b1;
    step(5);
  endtask : t_gate

  task automatic t_pair_b();
    hold(3'h2);
    conv();
    `CHK(p, 2'h1)
    `CHK(track_q, 3'h7)
    rd(3'h2);
    `CHK(w, {1'b1, 2'h1, 1'b0, res_a})
    rd(3'h3);
    `CHK(w, {1'b1, 2'h1, 1'b1, res_b})
    rd(3'h4);
    `CHK(w, 16'h0000)
  endtask : t_pair_b

  // B first, then A and C together, then a repeat of A while queued.
  task automatic t_order();
    hold(3'h2);
    step(60);
    hold(3'h5);
    step(100);
    hold(3'h1);
    conv();
    `CHK(p, 2'h1)
    conv();
    `CHK(p, 2'h0)
    conv();
    `CHK(p, 2'h2)
    step(1500);
    `CHK(busy_q, 1'b1)
  endtask : t_order

  task automatic t_level();
    hold_n <= 3'h6;
    conv();
    `CHK(p, 2'h0)
    step(1500);
    `CHK(busy_q, 1'b1)
    hold_n <= 3'h7;
    step(10);
  endtask : t_level

  task automatic t_cycle();
    for (int i = 0; i < 7; i++) begin
      rd(3'h6);
      `CHK(w, {1'b1, 3'(i % 6), i[0] ? res_b : res_a})
    end
  endtask : t_cycle

  // One pair fills all six registers, then drains in order to empty.
  task automatic t_fifo();
    rd(3'h7);
    `CHK(w[15], 1'b0)
    for (int k = 0; k < 3; k++) begin
      res_a <= 12'h100 + 12'(k);
      res_b <= 12'h200 + 12'(k);
      step(50);
      hold(3'h2);
      conv();
    end
    for (int i = 0; i < 7; i++) begin
      rd(3'h7);
      if (i < 6) begin
        `CHK(w, {1'b1, 2'h1, i[0],
          12'((i[0] ? 'h200 : 'h100) + i / 2)})
      end else begin
        `CHK(w[15], 1'b0)
      end
    end
  endtask : t_fifo

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    hold_n = 3'h7;
    rd_n = 1'b1;
    cs_n = 1'b1;
    mode = 3'h0;
    res_a = 12'hA5C;
    res_b = 12'h3C1;
    rst();
    t_reset();
    t_gate();
    t_pair_b();
    t_order();
    t_level();
    t_cycle();
    rst();
    t_fifo();
    report_and_stop();
  end
endmodule : tb_dah_top
